// File: shared/xdc_params.svh
// Constants for the DMA channel control block: offsets, bit positions, counts.
`ifndef XDC_PARAMS_SVH
`define XDC_PARAMS_SVH

// Channel count and the channels that may run XOR descriptors.
`define XDC_NUM_CHAN 8
`define XDC_XOR_CHANS 2

// Register offsets inside one channel window.
`define XDC_OFF_CMD 8'h84
`define XDC_OFF_START 8'h86
`define XDC_OFF_STATUS 8'h88

// Channel command bits and the bits that act once and read back as zero.
`define XDC_CMD_SUSPEND 2
`define XDC_CMD_RESET 5
`define XDC_CMD_ACTION_MASK 8'h24
`define XDC_CMD_RESET_VAL 8'h00

// Descriptor control bits.
`define XDC_DC_IRQ 0
`define XDC_DC_CMPL 3
`define XDC_DC_FENCE 4

// Descriptors that one channel may hold in flight.
`define XDC_MAX_OUT 2'h2

`define XDC_ZERO8 8'h00

`endif

// File: shared/xdc_pkg.sv
// Types shared by the DMA channel control block.
`default_nettype none
`include "xdc_params.svh"

package xdc_pkg;

   typedef logic [7:0] xdc_byte_t;
   typedef logic [2:0] xdc_chan_id_t;

   // Channel states; Gray steps along idle, run, suspend.
   typedef enum logic [1:0] {
      XDC_IDLE = 2'h0,
      XDC_RUN = 2'h1,
      XDC_SUSP = 2'h3,
      XDC_HALT = 2'h2
   } xdc_state_t;

   // Notification wishes kept for each descriptor in flight.
   typedef struct packed {
      logic is_xor;
      logic irq;
      logic cmpl;
   } xdc_note_t;

   typedef struct packed {
      xdc_state_t state;
      xdc_byte_t cmd;
      logic [1:0] cnt;
      logic head;
      xdc_note_t [1:0] note;
      logic fence_hold;
      logic xor_err;
      logic acc;
      logic nv;
      xdc_note_t nbits;
      logic abort;
   } xdc_chan_st_t;

   typedef struct packed {
      logic [7:0] fetch_enable;
      logic desc_accepted;
      logic xor_irq;
      logic xor_cmpl;
      logic leg_irq;
      logic leg_cmpl;
      xdc_chan_id_t note_chan;
      logic [7:0] chan_abort;
      xdc_byte_t rdata;
   } xdc_top_st_t;

endpackage : xdc_pkg

`default_nettype wire

// File: shared/xdc_chan_if.sv
// Signals between the control top and one channel.
`default_nettype none

interface xdc_chan_if;
   import xdc_pkg::*;

   logic wr_cmd;
   logic wr_start;
   xdc_byte_t wdata;
   logic take;
   logic take_xor;
   xdc_byte_t take_ctrl;
   logic done;
   logic fetch_ok;
   xdc_byte_t cmd;
   xdc_byte_t status;
   logic acc;
   logic nv;
   xdc_note_t note;
   logic abort;

   modport ctrl (
      output wr_cmd, wr_start, wdata, take, take_xor, take_ctrl, done,
      input fetch_ok, cmd, status, acc, nv, note, abort
   );
   modport chan (
      input wr_cmd, wr_start, wdata, take, take_xor, take_ctrl, done,
      output fetch_ok, cmd, status, acc, nv, note, abort
   );
endinterface : xdc_chan_if

`default_nettype wire

// File: hdl/xdc_channel.sv
// One DMA channel: run state, fence hold and in-flight notification queue.
`default_nettype none
`include "xdc_params.svh"

module xdc_channel
#(
   parameter bit XOR_OK = 1'b0
)
(
   input wire logic clock,
   input wire logic rst_n,
   xdc_chan_if.chan bus
);
   import xdc_pkg::*;

   xdc_chan_st_t s;
   xdc_chan_st_t next_s;
   logic fetch_ok;
   logic accept;
   logic good;
   logic cpl;
   logic tail;

   ////////////////////////////////////////////////////////////////////////////
   // A fenced descriptor holds the channel until all its work drains.
   assign fetch_ok = (s.state == XDC_RUN) && (s.cnt < `XDC_MAX_OUT) && !s.fence_hold;
   assign accept = bus.take && fetch_ok;
   // Legacy work is taken at any source alignment; no check exists here.
   assign good = accept && (!bus.take_xor || XOR_OK);
   assign cpl = bus.done && (s.cnt != 2'h0);
   assign tail = s.head ^ s.cnt[0];

   // Next state; the reset command is applied last so it overrides all else.
   always_comb
   begin
      next_s = s;
      next_s.acc = 1'b0;
      next_s.nv = 1'b0;
      next_s.abort = 1'b0;
      if (bus.wr_cmd)
      begin
         next_s.cmd = bus.wdata & ~`XDC_CMD_ACTION_MASK;
      end
      if (bus.wr_start && s.state != XDC_RUN)
      begin
         next_s.state = XDC_RUN;
         next_s.xor_err = 1'b0;
      end
      if (cpl)
      begin
         next_s.nv = 1'b1;
         next_s.nbits = s.note[s.head];
         next_s.head = ~s.head;
      end
      if (accept && !good)
      begin
         // XOR work on a legacy-only channel halts it and flags the fault.
         next_s.xor_err = 1'b1;
         next_s.state = XDC_HALT;
      end
      else if (good)
      begin
         next_s.acc = 1'b1;
         next_s.note[tail].is_xor = bus.take_xor;
         next_s.note[tail].irq = bus.take_ctrl[`XDC_DC_IRQ];
         next_s.note[tail].cmpl = bus.take_ctrl[`XDC_DC_CMPL];
         if (bus.take_ctrl[`XDC_DC_FENCE])
         begin
            next_s.fence_hold = 1'b1;
         end
      end
      next_s.cnt = 2'(s.cnt + {1'b0, good} - {1'b0, cpl});
      if (next_s.cnt == 2'h0)
      begin
         next_s.fence_hold = 1'b0;
      end
      if (bus.wr_cmd && bus.wdata[`XDC_CMD_SUSPEND] && s.state == XDC_RUN)
      begin
         next_s.state = XDC_SUSP;
      end
      if (bus.wr_cmd && bus.wdata[`XDC_CMD_RESET])
      begin
         // Work in flight, XOR included, is dropped and the engine told so.
         next_s.state = XDC_IDLE;
         next_s.cnt = 2'h0;
         next_s.head = 1'b0;
         next_s.fence_hold = 1'b0;
         next_s.xor_err = 1'b0;
         next_s.acc = 1'b0;
         next_s.nv = 1'b0;
         next_s.abort = 1'b1;
      end
   end

   // State register.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs to the top; the fetch permission is formed from state alone.
   assign bus.fetch_ok = fetch_ok;
   assign bus.cmd = s.cmd;
   assign bus.status = {2'h0, s.xor_err, s.fence_hold, s.cnt, s.state};
   assign bus.acc = s.acc;
   assign bus.nv = s.nv;
   assign bus.note = s.nbits;
   assign bus.abort = s.abort;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the channel's own behaviour.
   property p_fence_holds;
      @(posedge clock) disable iff (!rst_n)
      s.fence_hold && s.cnt != 2'h0 |-> !fetch_ok ##1 (s.fence_hold || s.cnt == 2'h0);
   endproperty
   a_fence_holds: assert property (p_fence_holds) else $error("fence let work pass");

   property p_suspend;
      @(posedge clock) disable iff (!rst_n)
      bus.wr_cmd && bus.wdata[`XDC_CMD_SUSPEND] && !bus.wdata[`XDC_CMD_RESET]
         && s.state == XDC_RUN |=> s.state == XDC_SUSP && !fetch_ok;
   endproperty
   a_suspend: assert property (p_suspend) else $error("suspend not taken");

   property p_reset;
      @(posedge clock) disable iff (!rst_n)
      bus.wr_cmd && bus.wdata[`XDC_CMD_RESET] |=> s.state == XDC_IDLE && s.cnt == 2'h0
         && s.abort ##1 (!s.abort || $past(bus.wr_cmd && bus.wdata[`XDC_CMD_RESET]));
   endproperty
   a_reset: assert property (p_reset) else $error("channel reset failed");

   property p_xor_refused;
      @(posedge clock) disable iff (!rst_n)
      accept && bus.take_xor && !XOR_OK |=> s.state == XDC_HALT && s.xor_err && !s.acc;
   endproperty
   a_xor_refused: assert property (p_xor_refused) else $error("xor ran on legacy channel");

   property p_stopped_quiet;
      @(posedge clock) disable iff (!rst_n)
      s.state != XDC_RUN && !bus.wr_start |=> !s.acc && s.state != XDC_RUN;
   endproperty
   a_stopped_quiet: assert property (p_stopped_quiet) else $error("stopped channel took work");

endmodule : xdc_channel

`default_nettype wire

// File: hdl/xdc_control.sv
// Control of an eight-channel DMA engine with XOR-capable channels 0 and 1.
// Behaviour
// - An XOR descriptor with control bit 0 set raises an XOR interrupt, and with bit 3 an XOR completion write, when it completes.
// - Control bit 4 fences a descriptor, so no later work starts before it has fully completed.
// - Writing one to bit 2 of the channel command register at 0x84 suspends that channel.
// - Writing one to bit 5 of the channel command register resets that channel, even with XOR work in progress.
// - Only channels 0 and 1 run XOR descriptors; channels 2 to 7 run legacy descriptors only.
// - Legacy copy descriptors are taken on every channel whatever the source alignment.
`default_nettype none
`include "xdc_params.svh"

module xdc_control
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire xdc_pkg::xdc_chan_id_t reg_chan,
   input wire xdc_pkg::xdc_byte_t reg_addr,
   input wire xdc_pkg::xdc_byte_t reg_wdata,
   output var xdc_pkg::xdc_byte_t reg_rdata,
   input wire logic desc_valid,
   input wire xdc_pkg::xdc_chan_id_t desc_chan,
   input wire logic desc_xor,
   input wire xdc_pkg::xdc_byte_t desc_ctrl,
   output var logic [7:0] fetch_enable,
   output var logic desc_accepted,
   input wire logic work_done,
   input wire xdc_pkg::xdc_chan_id_t work_chan,
   output var logic xor_irq,
   output var logic xor_cmpl_write,
   output var logic legacy_irq,
   output var logic legacy_cmpl_write,
   output var xdc_pkg::xdc_chan_id_t note_chan,
   output var logic [7:0] chan_abort
);
   import xdc_pkg::*;

   // True when a register address selects the given offset.
   function automatic logic xdc_hit(input xdc_byte_t addr, input xdc_byte_t off);
      xdc_hit = (addr == off);
   endfunction : xdc_hit

   xdc_top_st_t s;
   xdc_top_st_t next_s;
   logic [7:0] fetch_ok_w;
   logic [7:0] acc_w;
   logic [7:0] nv_w;
   logic [7:0] abort_w;
   logic [7:0] xor_irq_due;
   logic [7:0] xor_cmpl_due;
   xdc_note_t note_w [`XDC_NUM_CHAN];
   xdc_byte_t cmd_w [`XDC_NUM_CHAN];
   xdc_byte_t status_w [`XDC_NUM_CHAN];
   logic wr_cmd_hit;
   logic wr_start_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Register strobes; the channel number picks which window is addressed.
   assign wr_cmd_hit = reg_wr && xdc_hit(reg_addr, `XDC_OFF_CMD);
   assign wr_start_hit = reg_wr && xdc_hit(reg_addr, `XDC_OFF_START);

   xdc_chan_if cif [`XDC_NUM_CHAN] ();

   ////////////////////////////////////////////////////////////////////////////
   // One channel per slot; only the low slots are built able to run XOR work.
   for (genvar i = 0; i < `XDC_NUM_CHAN; i++)
   begin : g_ch
      assign cif[i].wr_cmd = wr_cmd_hit && (reg_chan == 3'(i));
      assign cif[i].wr_start = wr_start_hit && (reg_chan == 3'(i));
      assign cif[i].wdata = reg_wdata;
      assign cif[i].take = desc_valid && (desc_chan == 3'(i));
      assign cif[i].take_xor = desc_xor;
      assign cif[i].take_ctrl = desc_ctrl;
      assign cif[i].done = work_done && (work_chan == 3'(i));

      xdc_channel
      #(
         .XOR_OK(i < `XDC_XOR_CHANS)
      )
      u_ch
      (
         .clock(clock),
         .rst_n(rst_n),
         .bus(cif[i])
      );

      assign fetch_ok_w[i] = cif[i].fetch_ok;
      assign acc_w[i] = cif[i].acc;
      assign nv_w[i] = cif[i].nv;
      assign abort_w[i] = cif[i].abort;
      assign note_w[i] = cif[i].note;
      assign cmd_w[i] = cif[i].cmd;
      assign status_w[i] = cif[i].status;
      assign xor_irq_due[i] = cif[i].nv && cif[i].note.is_xor && cif[i].note.irq;
      assign xor_cmpl_due[i] = cif[i].nv && cif[i].note.is_xor && cif[i].note.cmpl;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output stage. Everything is registered once more so that every output
   // comes from a flop; the cost is one extra cycle on each answer.
   always_comb
   begin
      next_s = s;
      next_s.fetch_enable = fetch_ok_w;
      next_s.desc_accepted = |acc_w;
      next_s.chan_abort = abort_w;
      next_s.xor_irq = 1'b0;
      next_s.xor_cmpl = 1'b0;
      next_s.leg_irq = 1'b0;
      next_s.leg_cmpl = 1'b0;
      // At most one channel finishes per cycle, as completions arrive singly.
      for (int i = 0; i < `XDC_NUM_CHAN; i++)
      begin
         if (nv_w[i])
         begin
            next_s.note_chan = 3'(i);
            next_s.xor_irq = note_w[i].is_xor && note_w[i].irq;
            next_s.xor_cmpl = note_w[i].is_xor && note_w[i].cmpl;
            next_s.leg_irq = !note_w[i].is_xor && note_w[i].irq;
            next_s.leg_cmpl = !note_w[i].is_xor && note_w[i].cmpl;
         end
      end
      // Reads answer one cycle later; unmapped offsets read as zero.
      if (reg_rd)
      begin
         if (xdc_hit(reg_addr, `XDC_OFF_CMD))
            next_s.rdata = cmd_w[reg_chan];
         else if (xdc_hit(reg_addr, `XDC_OFF_STATUS))
            next_s.rdata = status_w[reg_chan];
         else
            next_s.rdata = `XDC_ZERO8;
      end
   end

   // State register.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ports.
   assign reg_rdata = s.rdata;
   assign fetch_enable = s.fetch_enable;
   assign desc_accepted = s.desc_accepted;
   assign xor_irq = s.xor_irq;
   assign xor_cmpl_write = s.xor_cmpl;
   assign legacy_irq = s.leg_irq;
   assign legacy_cmpl_write = s.leg_cmpl;
   assign note_chan = s.note_chan;
   assign chan_abort = s.chan_abort;

   ////////////////////////////////////////////////////////////////////////////
   // Checks tying port answers to their causes.
   property p_xor_irq;
      @(posedge clock) disable iff (!rst_n)
      (|xor_irq_due) |=> xor_irq && !legacy_irq;
   endproperty
   a_xor_irq: assert property (p_xor_irq) else $error("xor interrupt missing");

   property p_xor_cmpl;
      @(posedge clock) disable iff (!rst_n)
      (|xor_cmpl_due) |=> xor_cmpl_write && !legacy_cmpl_write;
   endproperty
   a_xor_cmpl: assert property (p_xor_cmpl) else $error("xor completion missing");

   property p_legacy_taken;
      @(posedge clock) disable iff (!rst_n)
      desc_valid && !desc_xor && fetch_ok_w[desc_chan]
         && !(wr_cmd_hit && reg_wdata[`XDC_CMD_RESET] && reg_chan == desc_chan)
         |-> ##2 desc_accepted;
   endproperty
   a_legacy_taken: assert property (p_legacy_taken) else $error("legacy work refused");

   property p_xor_low_only;
      @(posedge clock) disable iff (!rst_n)
      desc_valid && desc_xor && desc_chan >= 3'(`XDC_XOR_CHANS) |-> ##2 !desc_accepted;
   endproperty
   a_xor_low_only: assert property (p_xor_low_only) else $error("xor taken on high channel");

   property p_suspend_stops;
      @(posedge clock) disable iff (!rst_n)
      wr_cmd_hit && reg_wdata[`XDC_CMD_SUSPEND] |-> ##2 !fetch_enable[$past(reg_chan, 2)];
   endproperty
   a_suspend_stops: assert property (p_suspend_stops) else $error("fetch after suspend");

   property p_reset_aborts;
      @(posedge clock) disable iff (!rst_n)
      wr_cmd_hit && reg_wdata[`XDC_CMD_RESET] |-> ##2 chan_abort[$past(reg_chan, 2)];
   endproperty
   a_reset_aborts: assert property (p_reset_aborts) else $error("reset did not abort");

   // The channel index is taken from the cycle of the write, not of the check.
   property p_reset_no_fetch;
      @(posedge clock) disable iff (!rst_n)
      wr_cmd_hit && reg_wdata[`XDC_CMD_RESET] |-> ##2 !fetch_enable[$past(reg_chan, 2)];
   endproperty
   a_reset_no_fetch: assert property (p_reset_no_fetch) else $error("fetch after reset");

   // An offer that the channel is not willing to take is dropped without an answer.
   property p_refused_silent;
      @(posedge clock) disable iff (!rst_n)
      desc_valid && !fetch_ok_w[desc_chan] |-> ##2 !desc_accepted;
   endproperty
   a_refused_silent: assert property (p_refused_silent) else $error("refused offer taken");

   // XOR work on a legacy-only channel stops that channel from fetching.
   property p_halt_stops;
      @(posedge clock) disable iff (!rst_n)
      desc_valid && desc_xor && desc_chan >= 3'(`XDC_XOR_CHANS) && fetch_ok_w[desc_chan]
         |-> ##2 !fetch_enable[$past(desc_chan, 2)];
   endproperty
   a_halt_stops: assert property (p_halt_stops) else $error("halted channel fetches");

   // One finished descriptor gives notices of one kind only.
   property p_notes_exclusive;
      @(posedge clock) disable iff (!rst_n)
      xor_irq || xor_cmpl_write |-> !legacy_irq && !legacy_cmpl_write;
   endproperty
   a_notes_exclusive: assert property (p_notes_exclusive) else $error("mixed notices");

endmodule : xdc_control

`default_nettype wire

// File: testbench/xdc_engine_model.sv
// Engine model that reports finished descriptors on the completion port.
`default_nettype none

module xdc_engine_model
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic req,
   input wire xdc_pkg::xdc_chan_id_t req_chan,
   output logic work_done,
   output xdc_pkg::xdc_chan_id_t work_chan
);
   timeunit 1ns;
   timeprecision 1ps;
   import xdc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // One pulse for each request; the channel lines toggle while idle, so a stale value never helps.
   always @(negedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         work_done <= 1'b0;
         work_chan <= 3'h0;
      end
      else if (req)
      begin
         work_done <= 1'b1;
         work_chan <= req_chan;
      end
      else
      begin
         work_done <= 1'b0;
         work_chan <= ~work_chan;
      end
   end
endmodule : xdc_engine_model

`default_nettype wire

// File: testbench/xdc_control_tb.sv
// Self-checking bench for the DMA channel control block.
`default_nettype none

module xdc_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import xdc_pkg::*;

   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic desc_valid = 1'b0;
   logic desc_xor = 1'b0;
   logic req = 1'b0;
   xdc_chan_id_t reg_chan = 3'h0;
   xdc_chan_id_t desc_chan = 3'h0;
   xdc_chan_id_t req_chan = 3'h0;
   xdc_chan_id_t work_chan;
   xdc_chan_id_t note_chan;
   xdc_byte_t reg_addr = 8'h00;
   xdc_byte_t reg_wdata = 8'h00;
   xdc_byte_t desc_ctrl = 8'h00;
   xdc_byte_t reg_rdata;
   logic [7:0] fetch_enable;
   logic [7:0] chan_abort;
   logic desc_accepted, work_done, xor_irq, xor_cmpl_write, legacy_irq, legacy_cmpl_write;
   logic [7:0] n_acc, n_xi, n_xc, n_li, n_lc, ab;
   logic [31:0] seed = 32'h0000_0323;
   logic [31:0] r;
   logic [7:0] k;
   int errors = 0;
   int num_checks = 0;

   xdc_control u_dut (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_chan(reg_chan), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .desc_valid(desc_valid), .desc_chan(desc_chan), .desc_xor(desc_xor),
      .desc_ctrl(desc_ctrl), .fetch_enable(fetch_enable), .desc_accepted(desc_accepted),
      .work_done(work_done), .work_chan(work_chan), .xor_irq(xor_irq),
      .xor_cmpl_write(xor_cmpl_write), .legacy_irq(legacy_irq),
      .legacy_cmpl_write(legacy_cmpl_write), .note_chan(note_chan), .chan_abort(chan_abort));

   xdc_engine_model u_eng (.clock(clock), .rst_n(rst_n), .req(req), .req_chan(req_chan),
      .work_done(work_done), .work_chan(work_chan));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock at 25 MHz.
   initial
   begin
      forever #20 clock = ~clock;
   end

   // Pulses are tallied over a window, so a late or doubled pulse shows as a wrong count.
   always @(posedge clock)
   begin
      n_acc <= n_acc + desc_accepted;
      n_xi <= n_xi + xor_irq;
      n_xc <= n_xc + xor_cmpl_write;
      n_li <= n_li + legacy_irq;
      n_lc <= n_lc + legacy_cmpl_write;
      ab <= ab | chan_abort;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // Expected status byte: error, fence hold, count in flight, state.
   function automatic logic [7:0] st(xdc_state_t s, logic [1:0] n, logic f, logic e);
      return {2'b00, e, f, n, s};
   endfunction : st

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc

   task automatic clr();
      n_acc = 8'h00; n_xi = 8'h00; n_xc = 8'h00; n_li = 8'h00; n_lc = 8'h00; ab = 8'h00;
   endtask : clr

   task automatic wr(input xdc_chan_id_t c, input xdc_byte_t a, input xdc_byte_t d);
      reg_chan = c; reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
      cyc(2);
   endtask : wr

   // Read and compare; read data holds until the next read, so it is sampled late.
   task automatic rdc(input xdc_chan_id_t c, input xdc_byte_t a, input xdc_byte_t exp);
      reg_chan = c; reg_addr = a; reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      cyc(1);
      check(reg_rdata, exp);
   endtask : rdc

   // An offer held for n cycles; n of 2 makes a back-to-back second offer.
   task automatic offer(input xdc_chan_id_t c, input logic x, input xdc_byte_t d, input int n);
      desc_chan = c; desc_xor = x; desc_ctrl = d; desc_valid = 1'b1;
      cyc(n);
      desc_valid = 1'b0;
   endtask : offer

   task automatic fin(input xdc_chan_id_t c);
      req <= 1'b1;
      req_chan <= c;
      cyc(1);
      req <= 1'b0;
      cyc(5);
   endtask : fin

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      cyc(5000);
      errors++;
      close_out();
   end

   initial
   begin
      clr();
      cyc(20);
      rst_n = 1'b1;
      check(fetch_enable, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         rdc(3'(c), 8'h88, st(XDC_IDLE, 2'h0, 1'b0, 1'b0));
         wr(3'(c), 8'h86, 8'h00);
         rdc(3'(c), 8'h88, st(XDC_RUN, 2'h0, 1'b0, 1'b0));
      end
      check(fetch_enable, 8'hff);
      rdc(3'h0, 8'h90, 8'h00);
      wr(3'h0, 8'h84, 8'h41);
      rdc(3'h0, 8'h84, 8'h41);
      // Legacy work on channels 2 to 7 with legacy notices only; alignment has no port at all.
      repeat (24)
      begin
         r = xs();
         k = r[15:8] & 8'hef;
         clr();
         offer(3'h2 + 3'(r % 6), 1'b0, k, 1);
         fin(3'h2 + 3'(r % 6));
         check(n_acc, 8'h01);
         check(n_li, {7'h00, k[0]});
         check(n_lc, {7'h00, k[3]});
         check(n_xi | n_xc, 8'h00);
         check({5'h00, note_chan}, {5'h00, 3'h2 + 3'(r % 6)});
      end
      // Channel 0 runs XOR work with XOR notices, fence off.
      for (int i = 0; i < 4; i++)
      begin
         k = {4'h0, i[1], 2'b00, i[0]};
         clr();
         offer(3'h0, 1'b1, k, 1);
         fin(3'h0);
         check(n_acc, 8'h01);
         check(n_xi, {7'h00, k[0]});
         check(n_xc, {7'h00, k[3]});
         check(n_li | n_lc, 8'h00);
      end
      // A fenced null legacy descriptor on channel 1 blocks the back-to-back offer.
      clr();
      offer(3'h1, 1'b0, 8'h10, 2);
      rdc(3'h1, 8'h88, st(XDC_RUN, 2'h1, 1'b1, 1'b0));
      check(n_acc, 8'h01);
      fin(3'h1);
      offer(3'h1, 1'b0, 8'h00, 1);
      fin(3'h1);
      check(n_acc, 8'h02);
      // An XOR descriptor on a legacy channel is refused and halts it.
      clr();
      offer(3'h3, 1'b1, 8'h01, 1);
      cyc(3);
      rdc(3'h3, 8'h88, st(XDC_HALT, 2'h0, 1'b0, 1'b1));
      check(n_acc, 8'h00);
      check({7'h00, fetch_enable[3]}, 8'h00);
      wr(3'h3, 8'h86, 8'h00);
      rdc(3'h3, 8'h88, st(XDC_RUN, 2'h0, 1'b0, 1'b0));
      // Channels 1 to 7 are suspended before the busy XOR channel 0.
      clr();
      offer(3'h0, 1'b1, 8'h09, 1);
      for (int c = 1; c < 8; c++)
         wr(3'(c), 8'h84, 8'h04);
      wr(3'h0, 8'h84, 8'h04);
      rdc(3'h0, 8'h88, st(XDC_SUSP, 2'h1, 1'b0, 1'b0));
      rdc(3'h0, 8'h84, 8'h00);
      check(fetch_enable, 8'h00);
      offer(3'h1, 1'b0, 8'h00, 1);
      fin(3'h0);
      check(n_acc, 8'h01);
      check(n_xi, 8'h01);
      // Reset of channel 0 with XOR work in flight; reset beats suspend in one byte.
      wr(3'h0, 8'h86, 8'h00);
      clr();
      offer(3'h0, 1'b1, 8'h09, 1);
      wr(3'h0, 8'h84, 8'h24);
      cyc(2);
      check(ab, 8'h01);
      rdc(3'h0, 8'h88, st(XDC_IDLE, 2'h0, 1'b0, 1'b0));
      fin(3'h0);
      check(n_xi | n_xc, 8'h00);
      check(n_acc, 8'h01);
      close_out();
   end
endmodule : xdc_control_tb

`default_nettype wire
